// ===== bbfo_sequencer.sv
// billboard failover sequencer: pin watch, detach/reattach, detach timers
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps

// Operation
// - failure input active low triggers billboard
// - control bits 5:1 choose failure pin
// - control bit 0 enables failure trigger only
// - on failure force function detach
// - reattach presenting billboard 1.1 descriptors
// - timer A starts on address assignment
// - timer A defaults to twenty seconds
// - configured state reports unspecified error 00b
// - string request starts timer B
// - timer B defaults to twenty seconds
// - either timer expiry forces detach
// - then reattach with standard descriptors
// - timers count in 10 ms units
// - timer A low byte resets D0h
// - failure text comes from OTP memory
// - timer A high byte follows low byte
// - timer B has own low/high bytes
module bbfo_sequencer #(
  parameter int TICK_CYCLES = bbfo_pkg::TICK_CYCLES_DFLT
) (
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  input  wire logic [15:0]                    reg_addr,
  input  wire logic [7:0]                     reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output      logic [7:0]                     reg_rdata,
  input  wire logic [bbfo_pkg::PIN_COUNT-1:0] fail_pin_n,
  input  wire logic                           addr_set,
  input  wire logic                           alt_str_req,
  output      logic                           func_detach,
  output      logic                           billboard_mode,
  output      logic                           otp_text_sel,
  output      logic [1:0]                     cfg_code
);

  bbfo_pkg::bbfo_state_reg_t s_reg;
  bbfo_pkg::bbfo_state_reg_t s_next;

  localparam logic [bbfo_pkg::TICK_W-1:0] TICK_LAST =
    bbfo_pkg::TICK_W'(TICK_CYCLES - 1);

  // select code names a real pin: not reserved, not past the last one
  function automatic logic sel_valid(
    input logic [4:0] c
  );
    logic ok;
    ok = 1'b1;
    if (c == bbfo_pkg::SEL_RESERVED) begin
      ok = 1'b0;
    end
    if (32'(c) >= bbfo_pkg::PIN_COUNT) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // filtered level of the selected pin; no pin reads as idle high
  function automatic logic pin_pick(
    input logic [bbfo_pkg::PIN_COUNT-1:0] lv,
    input logic [4:0]                     c
  );
    logic p;
    p = 1'b1;
    for (int i = 0; i < bbfo_pkg::PIN_COUNT; i++) begin
      if (sel_valid(c) && 32'(c) == i) begin
        p = lv[i];
      end
    end
    return p;
  endfunction

  // an agreeing stage pair moves the filtered level; a one-cycle
  // glitch between stages 2 and 3 is simply not passed on
  function automatic logic [bbfo_pkg::PIN_COUNT-1:0] pin_filter(
    input logic [bbfo_pkg::PIN_COUNT-1:0] st2,
    input logic [bbfo_pkg::PIN_COUNT-1:0] st3,
    input logic [bbfo_pkg::PIN_COUNT-1:0] cur
  );
    logic [bbfo_pkg::PIN_COUNT-1:0] f;
    f = cur;
    for (int i = 0; i < bbfo_pkg::PIN_COUNT; i++) begin
      if (st2[i] == st3[i]) begin
        f[i] = st3[i];
      end
    end
    return f;
  endfunction

  // status: timer run flags, one-hot state, two zero bits
  function automatic logic [7:0] status_byte(
    input bbfo_pkg::bbfo_state_reg_t s
  );
    logic [7:0] b;
    b = {s.tmr_b.run, s.tmr_a.run, s.st, 2'h0};
    return b;
  endfunction

  // read decode, shared by the read path
  function automatic logic [7:0] rd_mux(
    input logic [15:0]               a,
    input bbfo_pkg::bbfo_state_reg_t s
  );
    logic [7:0] d;
    d = 8'h00;
    case (a)
      bbfo_pkg::CTRL_OFS:    d = s.ctrl;
      bbfo_pkg::TMRA_LO_OFS: d = s.tmr_a_cfg[7:0];
      bbfo_pkg::TMRA_HI_OFS: d = s.tmr_a_cfg[15:8];
      bbfo_pkg::TMRB_LO_OFS: d = s.tmr_b_cfg[7:0];
      bbfo_pkg::TMRB_HI_OFS: d = s.tmr_b_cfg[15:8];
      bbfo_pkg::STATUS_OFS:  d = status_byte(s);
      default:               d = 8'h00;
    endcase
    return d;
  endfunction

  // a running timer counts down one step per tick and holds at zero
  function automatic bbfo_pkg::bbfo_tmr_t tmr_step(
    input bbfo_pkg::bbfo_tmr_t t,
    input logic                 tick
  );
    bbfo_pkg::bbfo_tmr_t r;
    r = t;
    if (t.run && tick && t.cnt != 16'h0000) begin
      r.cnt = t.cnt - 16'h0001;
    end
    return r;
  endfunction

  // expiry on the tick that would bring the count to zero
  function automatic logic tmr_due(
    input bbfo_pkg::bbfo_tmr_t t,
    input logic                 tk
  );
    return t.run && tk && (t.cnt <= 16'h0001);
  endfunction

  // a started timer reloads from its configured tick count
  function automatic bbfo_pkg::bbfo_tmr_t tmr_load(
    input logic [15:0] cfg
  );
    bbfo_pkg::bbfo_tmr_t r;
    r.run = 1'b1;
    r.cnt = cfg;
    return r;
  endfunction

  logic       tick;
  logic       pin_lvl;
  logic       sel_ok;
  logic [4:0] sel;
  logic [4:0] new_sel;
  logic       a_exp;
  logic       b_exp;
  logic       hold_done;
  logic       fall_seen;

  always_comb begin
    s_next        = s_reg;
    s_next.rdata  = 8'h00;
    sel           = s_reg.ctrl[bbfo_pkg::SEL_MSB:bbfo_pkg::SEL_LSB];
    new_sel       = sel;
    sel_ok        = sel_valid(sel);
    pin_lvl       = pin_pick(s_reg.filt, sel);

    // three-stage pin capture; filtered level moves when stages 2 and 3 agree
    s_next.s1   = fail_pin_n;
    s_next.s2   = s_reg.s1;
    s_next.s3   = s_reg.s2;
    s_next.filt = pin_filter(s_reg.s2, s_reg.s3, s_reg.filt);
    s_next.prev = pin_lvl;

    // shared 10 ms tick
    tick = (s_reg.tick_cnt == TICK_LAST);
    if (tick) begin
      s_next.tick_cnt = '0;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        bbfo_pkg::CTRL_OFS: begin
          s_next.ctrl = reg_wdata & bbfo_pkg::CTRL_WMASK;
        end
        bbfo_pkg::TMRA_LO_OFS: begin
          s_next.tmr_a_cfg[7:0] = reg_wdata;
        end
        bbfo_pkg::TMRA_HI_OFS: begin
          s_next.tmr_a_cfg[15:8] = reg_wdata;
        end
        bbfo_pkg::TMRB_LO_OFS: begin
          s_next.tmr_b_cfg[7:0] = reg_wdata;
        end
        bbfo_pkg::TMRB_HI_OFS: begin
          s_next.tmr_b_cfg[15:8] = reg_wdata;
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      s_next.rdata = rd_mux(reg_addr, s_reg);
    end

    // a new select whose pin is already low must not read as a fall;
    // re-arm from the new pin so only a later fall starts a session
    if (reg_wr && reg_addr == bbfo_pkg::CTRL_OFS) begin
      new_sel     = s_next.ctrl[bbfo_pkg::SEL_MSB:bbfo_pkg::SEL_LSB];
      s_next.prev = pin_pick(s_next.filt, new_sel);
    end

    s_next.tmr_a = tmr_step(s_reg.tmr_a, tick);
    s_next.tmr_b = tmr_step(s_reg.tmr_b, tick);
    a_exp = tmr_due(s_reg.tmr_a, tick);
    b_exp = tmr_due(s_reg.tmr_b, tick);
    hold_done = tick && (s_reg.hold == bbfo_pkg::HOLD_TICKS - 4'h1);
    if (tick) begin
      s_next.hold = s_reg.hold + 4'h1;
    end

    // only a fresh fall counts; level changes elsewhere are ignored
    fall_seen = s_reg.ctrl[bbfo_pkg::CTRL_EN_BIT] && sel_ok &&
                s_reg.prev && !pin_lvl;

    case (s_reg.st)
      bbfo_pkg::ST_IDLE: begin
        if (fall_seen) begin
          s_next.st          = bbfo_pkg::ST_BB_DET;
          s_next.func.detach = 1'b1;
          s_next.hold        = 4'h0;
        end
      end
      bbfo_pkg::ST_BB_DET: begin
        if (hold_done) begin
          s_next.st             = bbfo_pkg::ST_BB_ON;
          s_next.func.detach    = 1'b0;
          s_next.func.billboard = 1'b1;
          s_next.func.cfg_code  = bbfo_pkg::CFG_UNSPEC;
        end
      end
      bbfo_pkg::ST_BB_ON: begin
        if (addr_set && !s_reg.tmr_a.run) begin
          s_next.tmr_a = tmr_load(s_reg.tmr_a_cfg);
        end
        if (alt_str_req && !s_reg.tmr_b.run) begin
          s_next.tmr_b = tmr_load(s_reg.tmr_b_cfg);
        end
        if (a_exp || b_exp) begin
          s_next.st             = bbfo_pkg::ST_STD_DET;
          s_next.func.detach    = 1'b1;
          s_next.func.billboard = 1'b0;
          s_next.hold           = 4'h0;
        end
      end
      bbfo_pkg::ST_STD_DET: begin
        if (hold_done) begin
          s_next.st          = bbfo_pkg::ST_IDLE;
          s_next.func.detach = 1'b0;
          s_next.tmr_a       = '0;
          s_next.tmr_b       = '0;
        end
      end
      default: begin
        s_next.st   = bbfo_pkg::ST_IDLE;
        s_next.func = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // pins idle high so no fall is seen out of reset
      s_reg.s1        <= '1;
      s_reg.s2        <= '1;
      s_reg.s3        <= '1;
      s_reg.filt      <= '1;
      s_reg.prev      <= 1'b1;
      s_reg.ctrl      <= bbfo_pkg::CTRL_RST;
      s_reg.tmr_a_cfg <= {bbfo_pkg::TMR_HI_RST,
                          bbfo_pkg::TMR_LO_RST};
      s_reg.tmr_b_cfg <= {bbfo_pkg::TMR_HI_RST,
                          bbfo_pkg::TMR_LO_RST};
      s_reg.tick_cnt  <= '0;
      s_reg.hold      <= 4'h0;
      s_reg.tmr_a     <= '0;
      s_reg.tmr_b     <= '0;
      s_reg.st        <= bbfo_pkg::ST_IDLE;
      // nothing forced on the function until a fall
      s_reg.func.detach    <= 1'b0;
      s_reg.func.billboard <= 1'b0;
      s_reg.func.cfg_code  <= bbfo_pkg::CFG_UNSPEC;
      s_reg.rdata     <= 8'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata      = s_reg.rdata;
  assign func_detach    = s_reg.func.detach;
  assign billboard_mode = s_reg.func.billboard;
  assign otp_text_sel   = s_reg.func.billboard;
  assign cfg_code       = s_reg.func.cfg_code;

endmodule

// ===== bbfo_pkg.sv
// shared constants and types for the failover sequencer
package bbfo_pkg;
  // register map, byte addresses on the register port
  localparam logic [15:0] CTRL_OFS    = 16'h0004;
  localparam logic [15:0] TMRA_LO_OFS = 16'h413c;
  localparam logic [15:0] TMRA_HI_OFS = 16'h413d;
  localparam logic [15:0] TMRB_LO_OFS = 16'h413e;
  localparam logic [15:0] TMRB_HI_OFS = 16'h413f;
  localparam logic [15:0] STATUS_OFS  = 16'h4140;

  // reset values
  localparam logic [7:0] CTRL_RST   = 8'h14;
  localparam logic [7:0] TMR_LO_RST = 8'hd0;
  localparam logic [7:0] TMR_HI_RST = 8'h07;

  // control byte layout
  localparam int         CTRL_EN_BIT  = 0;
  localparam int         SEL_LSB      = 1;
  localparam int         SEL_MSB      = 5;
  localparam logic [7:0] CTRL_WMASK   = 8'h3f;
  localparam logic [4:0] SEL_RESERVED = 5'h09;
  localparam int         PIN_COUNT    = 17;

  // capability descriptor configured-state code: unspecified error
  localparam logic [1:0] CFG_UNSPEC = 2'h0;

  // timing
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         TICK_MS       = 10;
  localparam int         TICK_CYCLES_DFLT =
    TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int         TICK_W        = 20;
  localparam logic [3:0] HOLD_TICKS    = 4'h5;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_BB_DET  = 4'h2,
    ST_BB_ON   = 4'h4,
    ST_STD_DET = 4'h8
  } bbfo_state_t;

  // signals presented to the internal function device
  typedef struct packed {
    logic       detach;
    logic       billboard;
    logic [1:0] cfg_code;
  } bbfo_func_t;

  // one detach timer
  typedef struct packed {
    logic        run;
    logic [15:0] cnt;
  } bbfo_tmr_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    logic [PIN_COUNT-1:0] filt;
    logic                 prev;
    logic [7:0]           ctrl;
    logic [15:0]          tmr_a_cfg;
    logic [15:0]          tmr_b_cfg;
    logic [TICK_W-1:0]    tick_cnt;
    logic [3:0]           hold;
    bbfo_tmr_t            tmr_a;
    bbfo_tmr_t            tmr_b;
    bbfo_state_t          st;
    bbfo_func_t           func;
    logic [7:0]           rdata;
  } bbfo_state_reg_t;
endpackage

// ===== bbfo_asserts.sv
// port checker for the failover sequencer
`timescale 1ns/1ps
module bbfo_asserts #(parameter int TICK_CYCLES = 8) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [16:0] fail_pin_n,
  input wire logic        addr_set,
  input wire logic        alt_str_req,
  input wire logic        func_detach,
  input wire logic        billboard_mode,
  input wire logic        otp_text_sel,
  input wire logic [1:0]  cfg_code
);
  logic       en_q;
  logic [9:0] hi_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_q   <= 1'b0;
      hi_cnt <= 10'h000;
    end else begin
      if (reg_wr && reg_addr == bbfo_pkg::CTRL_OFS)
        en_q <= reg_wdata[0];
      hi_cnt <= func_detach ? hi_cnt + 10'h001 : 10'h000;
    end
  end
  sequence s_det_rise;
    $rose(func_detach);
  endsequence
  sequence s_det_fall;
    $fell(func_detach);
  endsequence
  a_cfg_unspec: assert property (cfg_code == 2'h0)
    else $error("cfg code");
  a_otp_text: assert property (otp_text_sel == billboard_mode)
    else $error("text source");
  a_ctrl_rsvd: assert property (
    reg_rd && reg_addr == bbfo_pkg::CTRL_OFS |=> reg_rdata[7:6] == 2'h0)
    else $error("ctrl reserved bits");
  a_bb_entry: assert property ($rose(billboard_mode) |-> s_det_fall)
    else $error("billboard entry");
  a_bb_exit: assert property ($fell(billboard_mode) |-> s_det_rise)
    else $error("billboard exit");
  a_no_overlap: assert property (!(func_detach && billboard_mode))
    else $error("detach overlap");
  a_fail_gate: assert property (
    $rose(func_detach) && !$past(billboard_mode) |-> en_q)
    else $error("detach while disabled");
  a_hold_max: assert property (
    func_detach |-> hi_cnt <= 5 * TICK_CYCLES + 2)
    else $error("detach too long");
endmodule
bind bbfo_sequencer bbfo_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .fail_pin_n, .addr_set, .alt_str_req, .func_detach,
  .billboard_mode, .otp_text_sel, .cfg_code);

// ===== bbfo_far.sv
// far side: controller failure pin and host events
`timescale 1ns/1ps
module bbfo_far (
  input  wire logic        core_clk,
  input  wire logic [4:0]  sel,
  input  wire logic        go,
  input  wire logic        h_addr,
  input  wire logic        h_str,
  output      logic [16:0] fail_pin_n,
  output      logic        addr_set,
  output      logic        alt_str_req
);
  initial {fail_pin_n, addr_set, alt_str_req} = 19'h7fffc;
  // unused pins rest at their pull-up level
  always @(posedge core_clk) begin
    fail_pin_n <= go ? ~(17'h1 << sel) : 17'h1ffff;
    addr_set <= h_addr;
    alt_str_req <= h_str;
  end
endmodule

// ===== tb.sv
// self-checking bench for the failover sequencer
`timescale 1ns/1ps
module tb;
  localparam int T = 8;
  logic        core_clk, sys_rst, reg_wr, reg_rd, go, h_addr, h_str;
  logic        addr_set, alt_str_req, func_detach;
  logic        billboard_mode, otp_text_sel;
  logic [1:0]  cfg_code;
  logic [4:0]  sel;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] reg_addr;
  logic [16:0] fail_pin_n;
  int          err_total = 0, compares = 0, cyc = 0, c, nt;
  int          seed = 32'h0096eb0d;
  int          rm[int];
  int          sels[$] = '{10, 16, 0};
  bbfo_sequencer #(.TICK_CYCLES(T)) uut (.core_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fail_pin_n, .addr_set,
    .alt_str_req, .func_detach, .billboard_mode, .otp_text_sel, .cfg_code);
  bbfo_far far (.core_clk, .sel, .go, .h_addr, .h_str, .fail_pin_n,
    .addr_set, .alt_str_req);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic win(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("BAD %0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    if (rm.exists(a)) rm[a] = d & (a == 16'h0004 ? 8'h3f : 8'hff);
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(rm.exists(a) ? rm[a] : 0));
  endtask
  task automatic wait_det(input logic v);
    c = 0;
    while (func_detach !== v && c < 200) begin
      @(posedge core_clk);
      #1 c++;
    end
  endtask
  task automatic no_trig(input logic [7:0] ctl, input int s);
    wr(16'h0004, ctl);
    {sel, go} <= {5'(s), 1'b1};
    repeat (30) @(posedge core_clk);
    #1 chk(16'(func_detach), 16'h0);
    @(posedge core_clk);
    go <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic sess(input int s, input int b);
    nt = 2 + ($random(seed) & 3);
    wr(16'h413c + 16'(2 * b), 8'(nt));
    wr(16'h413d + 16'(2 * b), 8'h00);
    wr(16'h0004, 8'(2 * s + 1));
    {sel, go} <= {5'(s), 1'b1};
    wait_det(1'b1);
    win(c, 4, 8);
    wait_det(1'b0);
    win(c, 4 * T, 5 * T + 2);
    chk(16'({billboard_mode, otp_text_sel, cfg_code}), 16'hc);
    @(posedge core_clk);
    {h_addr, h_str} <= {b == 0, b != 0};
    @(posedge core_clk);
    {h_addr, h_str} <= 2'h0;
    wait_det(1'b1);
    win(c, (nt - 1) * T, nt * T + 4);
    chk(16'(billboard_mode), 16'h0);
    wait_det(1'b0);
    chk(16'({func_detach, billboard_mode}), 16'h0);
    @(posedge core_clk);
    go <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic summarize();
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {sys_rst, reg_wr, reg_rd, go, h_addr, h_str} = 6'h20;
    {reg_addr, reg_wdata, sel} = '0;
    rm[4] = 8'h14;
    for (int i = 0; i < 4; i++) rm[16'h413c + i] = i[0] ? 8'h07 : 8'hd0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rm[a]) rd(16'(a));
    rd(16'h4141);
    wr(16'h0004, 8'hff);
    rd(16'h0004);
    for (int i = 0; i < 4; i++) begin
      wr(16'h413c + 16'(i), 8'($random(seed)));
      rd(16'h413c + 16'(i));
    end
    no_trig(8'h14, 10);
    no_trig(8'h13, 9);
    foreach (sels[i]) sess(sels[i], i % 2);
    summarize();
  end
endmodule
